// >>> verilog/cib_pkg.sv
// shared constants and types for the can interrupt and bus-off control block
package cib_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [7:0] OFF_CTRL0  = 8'h00;
   localparam logic [7:0] OFF_CTRL1  = 8'h04;
   localparam logic [7:0] OFF_RXFLAG = 8'h08;
   localparam logic [7:0] OFF_RXIEN  = 8'h0C;
   localparam logic [7:0] OFF_TXFLAG = 8'h10;
   localparam logic [7:0] OFF_TXIEN  = 8'h14;
   localparam logic [7:0] OFF_MISC   = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   // control_reg_0 fields
   localparam int CTL0_ENABLE = 0;
   localparam int CTL0_INIT_REQUEST = 1;
   localparam int CTL0_SLEEP_REQUEST  = 2;
   localparam int CTL0_WAKE_DETECT_ENABLE   = 3;
   localparam int CTL0_INIT_ACKNOWLEDGE = 8;
   localparam int CTL0_SLEEP_ACKNOWLEDGE  = 9;
   // control_reg_1, misc_reg and status fields
   localparam int CTL1_BUSOFF_RECOVERY_MODE     = 0;
   localparam int MISC_BUSOFF_HOLD   = 0;
   localparam int STAT_BUSOFF   = 0;
   // rx_flag_reg and rx_irq_enable_reg fields
   localparam int RF_RXF  = 0;
   localparam int RF_OVR  = 1;
   localparam int RF_TST  = 2;
   localparam int RF_RST  = 4;
   localparam int RF_CSC  = 6;
   localparam int RF_WUP  = 7;
   // values after reset
   localparam logic RST_ENABLE = 1'b0;
   localparam logic RST_INIT_REQUEST = 1'b1;
   localparam logic RST_BUSOFF_RECOVERY_MODE   = 1'b0;
   localparam logic [2:0] RST_TXE = 3'h7;
   // error counter thresholds and recovery counts
   localparam logic [8:0] WARN_LIMIT    = 9'h060;
   localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
   localparam logic [8:0] BUSOFF_LIMIT  = 9'h100;
   localparam int RECESSIVE_RUN = 11;
   localparam int RECOVERY_SEQS = 128;
   // error state of one counter
   typedef enum logic [1:0] {ERR_ACTIVE, ERR_WARNING, ERR_PASSIVE, ERR_BUSOFF} cib_err_t;
   // sleep handshake states
   typedef enum logic [1:0] {SLP_AWAKE, SLP_PENDING, SLP_ASLEEP} cib_sleep_t;
   // events and levels coming from the protocol engine
   typedef struct packed {
      logic       rxEofStoredP;
      logic       rxQueueLoadP;
      logic       rxFifoOverflow;
      logic [2:0] txDoneP;
      logic       bitTickP;
      logic       busIdle;
   } cib_engine_t;
endpackage

// >>> verilog/cib_w1c_flags.sv
// sticky write-one-to-clear flag bank with set priority and hold condition
`timescale 1ns/1ns
module cib_w1c_flags #(
   parameter int             W        = 1,
   parameter logic [W-1:0]   RST_VAL  = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] setP,
   input  wire logic [W-1:0] hold,
   input  wire logic [W-1:0] clrP,
   output logic      [W-1:0] flags
);
   import cib_pkg::*;

   logic [W-1:0] flags_reg;
   logic [W-1:0] flags_next;
   logic [W-1:0] clrOk;

   // a clear only acts where the cause has gone; zero bits do nothing
   assign clrOk      = clrP & ~hold;                         // [R11] [R19]
   // set and hold are or'ed after the clear so a same-cycle event survives
   assign flags_next = (flags_reg & ~clrOk) | setP | hold;   // [R10] [R20]
   assign flags      = flags_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         flags_reg <= RST_VAL;
      end else begin
         flags_reg <= flags_next;
      end
   end
endmodule

// >>> verilog/cib_busoff_recovery.sv
// counts runs of recessive bits during bus-off until recovery may start
`timescale 1ns/1ns
module cib_busoff_recovery #(
   parameter int RUN_LEN  = cib_pkg::RECESSIVE_RUN,
   parameter int SEQ_CNT  = cib_pkg::RECOVERY_SEQS
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic startP,
   input  wire logic run,
   input  wire logic bitTickP,
   input  wire logic rxBit,
   output logic      done
);
   import cib_pkg::*;

   localparam int RW = $clog2(RUN_LEN + 1);
   localparam int SW = $clog2(SEQ_CNT + 1);
   localparam logic [RW-1:0] RUN_LAST = RW'(RUN_LEN - 1);
   localparam logic [SW-1:0] SEQ_LAST = SW'(SEQ_CNT - 1);

   logic [RW-1:0] runCnt_reg;
   logic [RW-1:0] runCnt_next;
   logic [SW-1:0] seqCnt_reg;
   logic [SW-1:0] seqCnt_next;
   logic          done_reg;
   logic          done_next;
   logic          runHit;

   // a dominant bit restarts the run; a full run bumps the sequence count
   assign runHit      = run && bitTickP && rxBit && (runCnt_reg == RUN_LAST);
   assign runCnt_next = startP ? '0 :
                        (!run || !bitTickP) ? runCnt_reg :
                        (!rxBit || runHit) ? '0 : runCnt_reg + RW'(1);
   assign seqCnt_next = startP ? '0 : (runHit && !done_reg) ? seqCnt_reg + SW'(1) : seqCnt_reg;
   // done after the last full run of the 128-by-11 count
   assign done_next   = startP ? 1'b0 : (done_reg || (runHit && seqCnt_reg == SEQ_LAST)); // [R15]
   assign done        = done_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         runCnt_reg <= '0;
         seqCnt_reg <= '0;
         done_reg   <= 1'b0;
      end else begin
         runCnt_reg <= runCnt_next;
         seqCnt_reg <= seqCnt_next;
         done_reg   <= done_next;
      end
   end
endmodule

// >>> verilog/cib_irq_busoff_ctrl.sv
// can interrupt, flag acknowledge, sleep/init handshake and bus-off recovery control
// Operation
// [R1] four separately maskable interrupt request outputs
// [R2] error request: status change or overrun, each enabled
// [R3] per tx buffer empty flag and enable
// [R4] receive full set after end of frame
// [R5] receive full set again on next queue load
// [R6] wake flag on bus activity while asleep
// [R7] receive fifo overflow sets overrun flag
// [R8] status change on critical range, states recorded
// [R9] request stands while any enabled flag set
// [R10] writing one clears the flag
// [R11] clear ignored while cause still present
// [R12] software clears only the flag it serviced
// [R13] enable, configure in init, then leave init
// [R14] reconfigure via sleep then init handshake
// [R15] automatic recovery after 128 runs of 11
// [R16] user mode also waits for hold cleared
// [R17] sleep only when idle with no pending transmit
// [R18] wake enable set before sleep, else masked
// [R19] writing zero to a flag does nothing
// [R20] set beats clear in the same cycle
`timescale 1ns/1ns
module cib_irq_busoff_ctrl (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire cib_pkg::cib_engine_t engEv,
   input  wire logic [8:0]           txErrCount,
   input  wire logic [7:0]           rxErrCount,
   input  wire logic                 canRx,
   input  wire logic                 powerDown,
   output logic                      irqWake,
   output logic                      irqError,
   output logic                      irqRx,
   output logic                      irqTx,
   output logic                      busOff,
   output logic                      busOffRecoverP,
   output logic                      sleepAck,
   output logic                      initAck,
   output logic                      canRxInternal
);
   import cib_pkg::*;

   // function: map a counter value onto its error state
   function automatic cib_err_t errState(input logic [8:0] cnt, input logic isTx);
      cib_err_t s;
      s = ERR_ACTIVE;
      if (isTx && cnt >= BUSOFF_LIMIT) begin
         s = ERR_BUSOFF;
      end else if (cnt >= PASSIVE_LIMIT) begin
         s = ERR_PASSIVE;
      end else if (cnt >= WARN_LIMIT) begin
         s = ERR_WARNING;
      end
      return s;
   endfunction

   // ---------------- wishbone slave ----------------
   logic        ack_reg;
   logic        ack_next;
   logic [31:0] rdat_reg;
   logic [31:0] rdat_next;
   logic        reqLive;
   logic        takeReq;
   logic        wrDo;
   logic        lane0;
   logic        hitCtrl0;
   logic        hitCtrl1;
   logic        hitRxFlag;
   logic        hitRxIen;
   logic        hitTxFlag;
   logic        hitTxIen;
   logic        hitMisc;
   logic        hitStatus;

   // one wait state: ack rises the cycle after the request, writes act on the ack edge
   assign reqLive   = wb_cyc_i && wb_stb_i;
   assign takeReq   = reqLive && !ack_reg;
   assign ack_next  = takeReq;
   assign wrDo      = reqLive && ack_reg && wb_we_i;
   assign lane0     = wrDo && wb_sel_i[0];
   assign hitCtrl0  = (wb_adr_i == OFF_CTRL0);
   assign hitCtrl1  = (wb_adr_i == OFF_CTRL1);
   assign hitRxFlag = (wb_adr_i == OFF_RXFLAG);
   assign hitRxIen  = (wb_adr_i == OFF_RXIEN);
   assign hitTxFlag = (wb_adr_i == OFF_TXFLAG);
   assign hitTxIen  = (wb_adr_i == OFF_TXIEN);
   assign hitMisc   = (wb_adr_i == OFF_MISC);
   assign hitStatus = (wb_adr_i == OFF_STATUS);

   // ---------------- control registers ----------------
   logic       enable_reg;
   logic       init_request_reg;
   logic       sleep_request_reg;
   logic       wake_detect_enable_reg;
   logic       busoff_recovery_mode_reg;
   logic [7:0] rxIen_reg;
   logic [2:0] txIen_reg;
   logic       init_acknowledge_reg;
   logic       init_acknowledge_next;
   logic       wrSlpRq;
   logic       slpRqWriteOk;
   logic       sleep_request_next;

   // busoff_recovery_mode is init-only; the rest may be written any time
   always_ff @(posedge clk) begin
      if (rst) begin
         enable_reg <= RST_ENABLE;
         init_request_reg <= RST_INIT_REQUEST;
         wake_detect_enable_reg   <= 1'b0;
         busoff_recovery_mode_reg   <= RST_BUSOFF_RECOVERY_MODE;
         rxIen_reg  <= '0;
         txIen_reg  <= '0;
      end else begin
         if (lane0 && hitCtrl0) begin
            enable_reg <= wb_dat_i[CTL0_ENABLE];
            init_request_reg <= wb_dat_i[CTL0_INIT_REQUEST];
            wake_detect_enable_reg   <= wb_dat_i[CTL0_WAKE_DETECT_ENABLE];     // [R18]
         end
         if (lane0 && hitCtrl1 && init_acknowledge_reg) begin
            busoff_recovery_mode_reg <= wb_dat_i[CTL1_BUSOFF_RECOVERY_MODE];      // [R13] [R14]
         end
         if (lane0 && hitRxIen) begin
            rxIen_reg <= wb_dat_i[7:0];
         end
         if (lane0 && hitTxIen) begin
            txIen_reg <= wb_dat_i[2:0];
         end
      end
   end

   // ---------------- pin synchroniser ----------------
   logic rxS1_reg;
   logic rxS2_reg;
   logic rxS3_reg;
   logic rxLevel_reg;

   // the pin level counts only once the second and third stage agree
   always_ff @(posedge clk) begin
      if (rst) begin
         rxS1_reg    <= 1'b1;
         rxS2_reg    <= 1'b1;
         rxS3_reg    <= 1'b1;
         rxLevel_reg <= 1'b1;
      end else begin
         rxS1_reg <= canRx;
         rxS2_reg <= rxS1_reg;
         rxS3_reg <= rxS2_reg;
         if (rxS2_reg == rxS3_reg) begin
            rxLevel_reg <= rxS3_reg;
         end
      end
   end

   // ---------------- sleep handshake ----------------
   cib_sleep_t  slp_reg;
   cib_sleep_t  slp_next;
   logic [2:0]  txEmpty;
   logic        txAllEmpty;
   logic        asleep;
   logic        rxMasked;
   logic        busActivity;
   logic        wakeEvent;
   logic        wakeIrqOk;

   assign asleep      = (slp_reg == SLP_ASLEEP);
   assign txAllEmpty  = &txEmpty;
   // without wake enable the bus is seen as recessive, so the block stays asleep
   assign rxMasked    = asleep && !wake_detect_enable_reg;                 // [R18]
   assign busActivity = !rxLevel_reg && !rxMasked;
   // in power-down the wake only counts if sleep was reached first and irq enabled
   assign wakeIrqOk   = !powerDown || rxIen_reg[RF_WUP];
   assign wakeEvent   = asleep && wake_detect_enable_reg && busActivity && wakeIrqOk; // [R6]
   // software cannot drop the sleep request before the acknowledge
   assign wrSlpRq      = lane0 && hitCtrl0;
   assign slpRqWriteOk = wb_dat_i[CTL0_SLEEP_REQUEST] || asleep;
   assign sleep_request_next   = wakeEvent ? 1'b0 :
                         (wrSlpRq && slpRqWriteOk) ? wb_dat_i[CTL0_SLEEP_REQUEST] : sleep_request_reg;

   // sleep waits for every transmit buffer empty and an idle bus
   always_comb begin
      slp_next = slp_reg;
      case (slp_reg)
         SLP_AWAKE: begin
            if (sleep_request_reg && enable_reg) begin
               slp_next = SLP_PENDING;
            end
         end
         SLP_PENDING: begin
            if (!sleep_request_reg) begin
               slp_next = SLP_AWAKE;
            end else if (txAllEmpty && engEv.busIdle) begin
               slp_next = SLP_ASLEEP;             // [R17]
            end
         end
         SLP_ASLEEP: begin
            if (!sleep_request_reg || wakeEvent) begin
               slp_next = SLP_AWAKE;
            end
         end
         default: begin
            slp_next = SLP_AWAKE;
         end
      endcase
   end

   // init acknowledge follows the request once the bus is quiet or asleep
   assign init_acknowledge_next = init_request_reg ? (init_acknowledge_reg || engEv.busIdle || asleep) : 1'b0;

   always_ff @(posedge clk) begin
      if (rst) begin
         slp_reg    <= SLP_AWAKE;
         sleep_request_reg  <= 1'b0;
         init_acknowledge_reg <= 1'b0;
      end else begin
         slp_reg    <= slp_next;
         sleep_request_reg  <= sleep_request_next;
         init_acknowledge_reg <= init_acknowledge_next;
      end
   end

   // ---------------- error state tracking ----------------
   cib_err_t txSt_reg;
   cib_err_t rxSt_reg;
   cib_err_t txStNow;
   cib_err_t rxStNow;
   logic     txStMove;
   logic     rxStMove;
   logic     statusChangeP;
   logic [1:0] txStRec_reg;
   logic [1:0] rxStRec_reg;

   assign txStNow  = errState(txErrCount, 1'b1);
   assign rxStNow  = errState({1'b0, rxErrCount}, 1'b0);
   assign txStMove = (txStNow != txSt_reg) && (txStNow != ERR_ACTIVE);
   assign rxStMove = (rxStNow != rxSt_reg) && (rxStNow != ERR_ACTIVE);
   // entering warning or passive on either counter, or bus-off on the transmit counter, raises the flag
   assign statusChangeP = txStMove || rxStMove;              // [R8]

   // the recorded states tell software which range was reached
   always_ff @(posedge clk) begin
      if (rst) begin
         txSt_reg    <= ERR_ACTIVE;
         rxSt_reg    <= ERR_ACTIVE;
         txStRec_reg <= '0;
         rxStRec_reg <= '0;
      end else begin
         txSt_reg <= txStNow;
         rxSt_reg <= rxStNow;
         if (statusChangeP) begin
            txStRec_reg <= txStNow;               // [R8]
            rxStRec_reg <= rxStNow;
         end
      end
   end

   // ---------------- flags ----------------
   logic [3:0] rxFlags;
   logic [3:0] rxSet;
   logic [3:0] rxHold;
   logic [3:0] rxClr;
   logic       clrRx;
   logic       clrTx;
   logic       rxfSet;

   // a queued message does not move to the foreground while asleep
   assign rxfSet = engEv.rxEofStoredP || (engEv.rxQueueLoadP && !asleep); // [R4] [R5]
   // flag order: wake, status change, overrun, receive full
   assign rxSet  = {wakeEvent, statusChangeP, 1'b0, rxfSet};
   assign rxHold = {1'b0, 1'b0, engEv.rxFifoOverflow, 1'b0};  // [R7]
   assign clrRx  = lane0 && hitRxFlag;
   assign clrTx  = lane0 && hitTxFlag;
   assign rxClr  = clrRx ? {wb_dat_i[RF_WUP], wb_dat_i[RF_CSC], wb_dat_i[RF_OVR],
                            wb_dat_i[RF_RXF]} : 4'h0;         // [R10] [R19]

   cib_w1c_flags #(
      .W       (4),
      .RST_VAL (4'h0)
   ) u_rxFlags (
      .clk   (clk),
      .rst   (rst),
      .setP  (rxSet),
      .hold  (rxHold),
      .clrP  (rxClr),
      .flags (rxFlags)
   );

   // a buffer goes empty when its message is sent or aborted; clearing schedules it
   cib_w1c_flags #(
      .W       (3),
      .RST_VAL (RST_TXE)
   ) u_txFlags (
      .clk   (clk),
      .rst   (rst),
      .setP  (engEv.txDoneP),                                 // [R3]
      .hold  (3'h0),
      .clrP  (clrTx ? wb_dat_i[2:0] : 3'h0),
      .flags (txEmpty)
   );

   // ---------------- bus-off and recovery ----------------
   logic busOff_reg;
   logic busOffEnter;
   logic hold_reg;
   logic recCountDone;
   logic recoverGo;
   logic recoverP_reg;

   assign busOffEnter = (txStNow == ERR_BUSOFF) && !busOff_reg;
   // user mode needs both the count and a cleared hold, in either order
   assign recoverGo = busOff_reg && recCountDone && (!busoff_recovery_mode_reg || !hold_reg); // [R15] [R16]

   // counting pauses while asleep since the protocol clocks are stopped
   cib_busoff_recovery #(
      .RUN_LEN (RECESSIVE_RUN),
      .SEQ_CNT (RECOVERY_SEQS)
   ) u_recovery (
      .clk      (clk),
      .rst      (rst),
      .startP   (busOffEnter),
      .run      (busOff_reg && enable_reg && !asleep),
      .bitTickP (engEv.bitTickP),
      .rxBit    (rxLevel_reg),
      .done     (recCountDone)
   );

   // hold is raised on entry in user mode and cleared by writing one
   always_ff @(posedge clk) begin
      if (rst) begin
         busOff_reg   <= 1'b0;
         hold_reg     <= 1'b0;
         recoverP_reg <= 1'b0;
      end else begin
         busOff_reg   <= busOffEnter ? 1'b1 : recoverGo ? 1'b0 : busOff_reg;
         recoverP_reg <= recoverGo;
         if (busOffEnter && busoff_recovery_mode_reg) begin
            hold_reg <= 1'b1;
         end else if (lane0 && hitMisc && wb_dat_i[MISC_BUSOFF_HOLD]) begin
            hold_reg <= 1'b0;                     // [R16]
         end
      end
   end

   // ---------------- read mux ----------------
   logic [31:0] rdCtrl0;
   logic [31:0] rdRxFlag;

   assign rdCtrl0  = {22'h0, asleep, init_acknowledge_reg, 4'h0, wake_detect_enable_reg, sleep_request_reg,
                      init_request_reg, enable_reg};
   assign rdRxFlag = {24'h0, rxFlags[3], rxFlags[2], rxStRec_reg, txStRec_reg,
                      rxFlags[1], rxFlags[0]};
   // unmapped addresses answer with zero and ignore writes
   assign rdat_next = !takeReq  ? rdat_reg :
                      hitCtrl0  ? rdCtrl0 :
                      hitCtrl1  ? {31'h0, busoff_recovery_mode_reg} :
                      hitRxFlag ? rdRxFlag :
                      hitRxIen  ? {24'h0, rxIen_reg} :
                      hitTxFlag ? {29'h0, txEmpty} :
                      hitTxIen  ? {29'h0, txIen_reg} :
                      hitMisc   ? {31'h0, hold_reg} :
                      hitStatus ? {31'h0, busOff_reg} : 32'h0;

   // ---------------- output registers ----------------
   logic irqWake_reg;
   logic irqErr_reg;
   logic irqRx_reg;
   logic irqTx_reg;
   logic rxInt_reg;

   // requests are a level for as long as an enabled flag stays set
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_reg     <= 1'b0;
         rdat_reg    <= '0;
         irqWake_reg <= 1'b0;
         irqErr_reg  <= 1'b0;
         irqRx_reg   <= 1'b0;
         irqTx_reg   <= 1'b0;
         rxInt_reg   <= 1'b1;
      end else begin
         ack_reg     <= ack_next;
         rdat_reg    <= rdat_next;
         irqWake_reg <= rxFlags[3] && rxIen_reg[RF_WUP];                        // [R1] [R9]
         irqErr_reg  <= (rxFlags[2] && rxIen_reg[RF_CSC]) ||
                        (rxFlags[1] && rxIen_reg[RF_OVR]);                      // [R2] [R9]
         irqRx_reg   <= rxFlags[0] && rxIen_reg[RF_RXF];                        // [R1] [R9]
         irqTx_reg   <= |(txEmpty & txIen_reg);                                 // [R3] [R9]
         rxInt_reg   <= rxMasked ? 1'b1 : rxLevel_reg;
      end
   end

   assign wb_ack_o       = ack_reg;
   assign wb_dat_o       = rdat_reg;
   assign irqWake        = irqWake_reg;
   assign irqError       = irqErr_reg;
   assign irqRx          = irqRx_reg;
   assign irqTx          = irqTx_reg;
   assign busOff         = busOff_reg;
   assign busOffRecoverP = recoverP_reg;
   assign sleepAck       = asleep;
   assign initAck        = init_acknowledge_reg;
   assign canRxInternal  = rxInt_reg;
endmodule

// >>> tb/cib_irq_busoff_ctrl_asserts.sv
// port checker for the can interrupt and bus-off control block
`timescale 1ns/1ns
module cib_irq_busoff_ctrl_asserts
   import cib_pkg::*;
(
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_ack_o,
   input wire cib_pkg::cib_engine_t engEv,
   input wire logic [8:0]           txErrCount,
   input wire logic                 irqTx,
   input wire logic                 busOff,
   input wire logic                 busOffRecoverP,
   input wire logic                 sleepAck,
   input wire logic                 initAck
);
   // two ticks of slack for where the engine starts its count
   localparam int MIN_TICKS = RECESSIVE_RUN * RECOVERY_SEQS - 2;
   logic [11:0] tickCnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // bit ticks seen while off the bus; an early exit would show a short count
   always_ff @(posedge clk) begin
      if (rst || !busOff)
         tickCnt <= '0;
      else if (engEv.bitTickP)
         tickCnt <= tickCnt + 12'h1;
   end
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   busoff_entry_a: assert property (txErrCount >= BUSOFF_LIMIT && !busOff |=> busOff)
      else $error("bus-off not entered");
   recover_pulse_a: assert property (busOffRecoverP |-> !busOff && $past(busOff))
      else $error("recovery pulse without bus-off exit");
   recover_count_a: assert property ($fell(busOff) |-> tickCnt >= MIN_TICKS)
      else $error("bus-off left before recessive run count");
   sleep_idle_a: assert property ($rose(sleepAck) |-> $past(engEv.busIdle))
      else $error("sleep entered on busy bus");
   init_idle_a: assert property ($rose(initAck) |-> $past(engEv.busIdle) || $past(sleepAck))
      else $error("init acknowledged on busy bus");
   irq_drop_a: assert property ($fell(irqTx) |-> $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
      else $error("tx request dropped without a write");
   cover property ($rose(busOff));
   cover property (busOffRecoverP);
   cover property ($rose(sleepAck));
endmodule

bind cib_irq_busoff_ctrl cib_irq_busoff_ctrl_asserts chk (
   .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .engEv(engEv), .txErrCount(txErrCount), .irqTx(irqTx), .busOff(busOff),
   .busOffRecoverP(busOffRecoverP), .sleepAck(sleepAck), .initAck(initAck));

// >>> tb/cib_can_node.sv
// bus-side stand-in: bit ticks, bus level and idle indication
`timescale 1ns/1ns
module cib_can_node (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic quiet,
   output logic      canRx,
   output logic      bitTickP,
   output logic      busIdle
);
   logic phase;
   // one bit per two clocks keeps the long recovery run affordable
   always_ff @(posedge clk) begin
      phase <= rst ? 1'b0 : !phase;
      bitTickP <= !rst && phase;
   end
   // an active bus holds dominant long enough for the pin filter to agree;
   // a level that flips every clock would never pass the second and third stage vote
   assign canRx = quiet ? 1'b1 : 1'b0;
   assign busIdle = quiet;
endmodule

// >>> tb/cib_irq_busoff_ctrl_bench.sv
// self-checking bench for the can interrupt and bus-off control block
`timescale 1ns/1ns
module cib_irq_busoff_ctrl_bench;
   import cib_pkg::*;
   logic        clk, rst, cyc, stb, we, ack, canRx, tick, idle;
   logic [7:0]  adr;
   logic [31:0] dat, rdat, q;
   logic        rxEof, rxLoad, ovf, quiet;
   logic [2:0]  txDone;
   logic [8:0]  txErr;
   logic        irqW, irqE, irqR, irqT, bOff, sleep_acknowledge;
   int          numErrors = 0;
   int          totalChecks = 0;
   int          cycles = 0;
   cib_engine_t engEv;
   assign engEv = {rxEof, rxLoad, ovf, txDone, tick, idle};
   cib_irq_busoff_ctrl uut (
      .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .engEv(engEv), .txErrCount(txErr), .rxErrCount(8'h00), .canRx(canRx),
      .powerDown(1'b0), .irqWake(irqW), .irqError(irqE), .irqRx(irqR), .irqTx(irqT),
      .busOff(bOff), .busOffRecoverP(), .sleepAck(sleep_acknowledge), .initAck(), .canRxInternal());
   cib_can_node node (.clk(clk), .rst(rst), .quiet(quiet), .canRx(canRx),
      .bitTickP(tick), .busIdle(idle));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      totalChecks++;
      if (g !== e) begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // bounded wait for the bus-off level to clear
   task automatic wait_on(input int lim);
      int n;
      n = 0;
      while (bOff !== 1'b0 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // hang guard: roughly two and a half times the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 16000) begin
         numErrors++;
         wrap_up();
      end
   end
   initial begin
      {rst, cyc, stb, we, adr, dat} = {1'b1, 43'h0};
      {rxEof, rxLoad, ovf, txDone, txErr, quiet} = {15'h0, 1'b1};
      tk(6);
      rst <= 1'b0;
      rd(OFF_TXFLAG, 32'h7, "txEmpty");
      wr(OFF_CTRL0, 32'h3);
      rd(OFF_CTRL0, 32'h103, "ctrl0");
      wr(OFF_TXIEN, 32'h4);
      tk(2);
      chk("irqTx", 1, irqT);
      wr(OFF_TXFLAG, 32'h4);
      tk(2);
      chk("irqTx", 0, irqT);
      wr(OFF_TXFLAG, 32'h0);
      rd(OFF_TXFLAG, 32'h3, "txEmpty");
      txDone <= 3'h4;
      @(posedge clk);
      txDone <= 3'h0;
      tk(2);
      chk("irqTx", 1, irqT);
      $display("test tx done");
      wr(OFF_RXIEN, 32'hC3);
      rxEof <= 1'b1;
      @(posedge clk);
      rxEof <= 1'b0;
      tk(2);
      chk("irqRx", 1, irqR);
      wr(OFF_RXFLAG, 32'h1);
      tk(2);
      chk("irqRx", 0, irqR);
      rxLoad <= 1'b1;
      @(posedge clk);
      rxLoad <= 1'b0;
      tk(2);
      chk("irqRx", 1, irqR);
      wr(OFF_RXFLAG, 32'h1);
      ovf <= 1'b1;
      tk(2);
      wr(OFF_RXFLAG, 32'h2);
      rd(OFF_RXFLAG, 32'h2, "overrun");
      chk("irqError", 1, irqE);
      ovf <= 1'b0;
      wr(OFF_RXFLAG, 32'h2);
      tk(2);
      chk("irqError", 0, irqE);
      $display("test rx done");
      txErr <= 9'h100;
      tk(3);
      chk("busOff", 1, bOff);
      rd(OFF_RXFLAG, 32'h4C, "status");
      txErr <= 9'h000;
      wait_on(4000);
      chk("busOff", 0, bOff);
      wr(OFF_CTRL1, 32'h1);
      txErr <= 9'h100;
      tk(3);
      txErr <= 9'h000;
      tk(3100);
      chk("busOff", 1, bOff);
      wr(OFF_MISC, 32'h1);
      wait_on(20);
      chk("busOff", 0, bOff);
      $display("test bus-off done");
      wr(OFF_CTRL0, 32'hF);
      tk(3);
      chk("sleepAck", 1, sleep_acknowledge);
      quiet <= 1'b0;
      tk(8);
      chk("sleepAck", 0, sleep_acknowledge);
      chk("irqWake", 1, irqW);
      quiet <= 1'b1;
      $display("test sleep done");
      wrap_up();
   end
endmodule
